// [dv/tb_special_reg_operand_status.sv]
// Self-checking bench for the special-register operand and status bank.
`timescale 1ns/1ns
module tb_special_reg_operand_status import sprb_pkg::*;;
    // Every input starts at a known level so that nothing floats before reset.
    logic clk = 1'h0, sys_rst = 1'h1, spr_wr_en = 1'h0, spr_rd_en = 1'h0, opnd_valid = 1'h0;
    logic sp_wr_valid = 1'h0, ipset_valid = 1'h0, alu_arith_valid = 1'h0, alu_logic_valid = 1'h0;
    logic alu_carry_out = 1'h0, alu_carry_msb = 1'h0, div_end = 1'h0, div_force_one = 1'h0;
    logic alu_bit32 = 1'h0, byte_order_bit = 1'h0, ls_valid = 1'h0, set_byte_ptr_flag = 1'h0;
    logic extract_valid = 1'h0, fp_done = 1'h0, int_done = 1'h0, int_is_div = 1'h0;
    logic int_overflow = 1'h0, int_div_zero = 1'h0;
    logic [7:0] spr_wr_num = 8'h00, spr_rd_num = 8'h00, result_reg_field = 8'h00;
    logic [7:0] src_a_reg_field = 8'h00, src_b_reg_field = 8'h00, ipset_result = 8'h00;
    logic [7:0] ipset_src_a = 8'h00, ipset_src_b = 8'h00;
    logic [31:0] spr_wr_data = 32'h0, sp_wr_value = 32'h0, alu_result = 32'h0;
    logic [31:0] extract_hi = 32'h0, extract_lo = 32'h0;
    logic [5:0] fp_exc = 6'h00;
    logic [31:0] spr_rd_data_q, extract_q;
    logic [7:0] result_abs_q, src_a_abs_q, src_b_abs_q;
    logic [5:0] fp_trap_cause_q;
    logic [1:0] byte_lane_sel;
    sprb_round_t round_mode_field;
    logic spr_rd_valid_q, opnd_done_q, alu_carry_in, div_step_add, half_lane_sel;
    logic extract_done_q, fast_float_select, fp_trap_q, range_trap_q;
    int bad_count = 0, num_checks = 0;

    // Every bench signal carries the name of the port it drives or watches.
    sprb_top i_dut (.*);

    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Drops every strobe at the taking edge, then lets that edge's updates land.
    task automatic settle();
        @(posedge clk);
        {spr_wr_en, spr_rd_en, opnd_valid, sp_wr_valid, ipset_valid, alu_arith_valid} <= '0;
        {alu_logic_valid, div_end, ls_valid, extract_valid, fp_done, int_done} <= '0;
        #1;
    endtask

    task automatic wr(input logic [7:0] n, input logic [31:0] d);
        @(posedge clk);
        spr_wr_en <= 1'h1;
        spr_wr_num <= n;
        spr_wr_data <= d;
        settle();
    endtask

    // Read data and its valid pulse both land at the taking edge and are checked just after it.
    task automatic rd(input logic [7:0] n, input logic [31:0] exp);
        @(posedge clk);
        spr_rd_en <= 1'h1;
        spr_rd_num <= n;
        settle();
        chk(32'(spr_rd_valid_q), 32'h1);
        chk(spr_rd_data_q, exp);
    endtask

    task automatic t_pointers();
        wr(SPR_PTR_RESULT, 32'hFFFFFFFF);
        rd(SPR_PTR_RESULT, 32'h000003FC);
        @(posedge clk);
        {spr_wr_en, spr_wr_num, spr_wr_data} <= {1'h1, SPR_PTR_SRC_A, 32'h00000155};
        @(posedge clk);
        {spr_wr_en, spr_rd_en, spr_rd_num} <= {1'h0, 1'h1, SPR_PTR_SRC_A};
        settle();
        chk(spr_rd_data_q, 32'h00000154);
        wr(8'h83, 32'hFFFFFFFF);
        rd(8'h83, 32'h00000000);
    endtask

    // A stack-pointer base of 8 must shift literal local fields but never pointer values.
    task automatic t_operands();
        @(posedge clk);
        {ipset_valid, sp_wr_valid} <= 2'h3;
        {ipset_result, ipset_src_a, ipset_src_b} <= 24'h059042;
        sp_wr_value <= 32'h00000020;
        settle();
        @(posedge clk);
        opnd_valid <= 1'h1;
        {result_reg_field, src_a_reg_field, src_b_reg_field} <= 24'h000081;
        settle();
        chk({8'h0, result_abs_q, src_a_abs_q, src_b_abs_q}, 32'h00059089);
        chk(32'(opnd_done_q), 32'h1);
        @(posedge clk);
        opnd_valid <= 1'h1;
        {result_reg_field, src_a_reg_field, src_b_reg_field} <= 24'h10FF00;
        settle();
        chk({8'h0, result_abs_q, src_a_abs_q, src_b_abs_q}, 32'h00108742);
        @(posedge clk);
        {sp_wr_valid, sp_wr_value} <= {1'h1, 32'h00000040};
        @(posedge clk);
        {sp_wr_valid, opnd_valid} <= 2'h1;
        {result_reg_field, src_a_reg_field, src_b_reg_field} <= 24'h108000;
        settle();
        chk({8'h0, result_abs_q, src_a_abs_q, src_b_abs_q}, 32'h00109042);
        rd(SPR_PTR_SRC_A, 32'h00000240);
    endtask

    task automatic fp_op(input logic [5:0] e, input logic exp);
        @(posedge clk);
        fp_done <= 1'h1;
        fp_exc <= e;
        settle();
        chk(32'(fp_trap_q), 32'(exp));
        if (exp) chk(32'(fp_trap_cause_q), 32'(e));
    endtask

    task automatic t_float_env();
        wr(SPR_FLOAT_ENV, 32'hFFFFFFFF);
        rd(SPR_FLOAT_ENV, 32'h000001FF);
        chk(32'(fast_float_select), 32'h1);
        for (int m = 0; m < 4; m++) begin
            wr(SPR_FLOAT_ENV, 32'(m << 6));
            chk(32'(round_mode_field), 32'(m));
            chk(32'(fast_float_select), 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            wr(SPR_FLOAT_ENV, 32'h0);
            fp_op(6'(1 << i), 1'h1);
            wr(SPR_FLOAT_ENV, 32'(1 << i));
            fp_op(6'(1 << i), 1'h0);
        end
    endtask

    task automatic int_op(input logic dv, input logic ov, input logic dz, input logic exp);
        @(posedge clk);
        {int_done, int_is_div, int_overflow, int_div_zero} <= {1'h1, dv, ov, dz};
        settle();
        chk(32'(range_trap_q), 32'(exp));
    endtask

    task automatic t_int_env();
        wr(SPR_WHOLE_ENV, 32'h0);
        int_op(1'h1, 1'h1, 1'h0, 1'h1);
        int_op(1'h0, 1'h1, 1'h0, 1'h1);
        wr(SPR_WHOLE_ENV, 32'hFFFFFFFF);
        rd(SPR_WHOLE_ENV, 32'h00000003);
        int_op(1'h1, 1'h1, 1'h0, 1'h0);
        int_op(1'h1, 1'h0, 1'h1, 1'h1);
        int_op(1'h0, 1'h1, 1'h0, 1'h0);
    endtask

    task automatic alu_ev(input logic ar, input logic [31:0] r, input logic co, input logic cm);
        @(posedge clk);
        {alu_arith_valid, alu_logic_valid} <= {ar, !ar};
        {alu_result, alu_carry_out, alu_carry_msb} <= {r, co, cm};
        settle();
    endtask

    task automatic dv_end(input logic f, input logic b);
        @(posedge clk);
        {div_end, div_force_one, alu_bit32} <= {1'h1, f, b};
        settle();
    endtask

    // A logical result must leave overflow and carry as the arithmetic one set them.
    task automatic t_alu();
        chk(32'(div_step_add), 32'h1);
        alu_ev(1'h1, 32'h80000000, 1'h1, 1'h0);
        rd(SPR_ALU_STATUS, 32'h00000680);
        chk(32'(alu_carry_in), 32'h1);
        alu_ev(1'h0, 32'h0, 1'h0, 1'h0);
        rd(SPR_ALU_STATUS, 32'h00000580);
        alu_ev(1'h1, 32'h00000001, 1'h0, 1'h1);
        chk(32'(alu_carry_in), 32'h0);
        dv_end(1'h0, 1'h0);
        rd(SPR_ALU_STATUS, 32'h00000C00);
        chk(32'(div_step_add), 32'h0);
        dv_end(1'h0, 1'h1);
        chk(32'(div_step_add), 32'h1);
        dv_end(1'h1, 1'h1);
        chk(32'(div_step_add), 32'h0);
        wr(SPR_ALU_STATUS, 32'hFFFFFFFF);
        rd(SPR_ALU_STATUS, 32'h00000FFF);
    endtask

    task automatic t_lanes();
        wr(SPR_BYTE_PTR, 32'hFFFFFFFE);
        rd(SPR_ALU_STATUS, 32'h00000FDF);
        chk({byte_lane_sel, half_lane_sel}, 32'h5);
        @(posedge clk);
        byte_order_bit <= 1'h1;
        {ls_valid, set_byte_ptr_flag} <= 2'h3;
        settle();
        rd(SPR_BYTE_PTR, 32'h0);
        chk({byte_lane_sel, half_lane_sel}, 32'h7);
        @(posedge clk);
        byte_order_bit <= 1'h0;
        ls_valid <= 1'h1;
        settle();
        rd(SPR_BYTE_PTR, 32'h3);
    endtask

    task automatic t_funnel();
        logic [63:0] both;
        both = 64'h123456789ABCDEF0;
        for (int s = 0; s < 36; s += 31) begin
            wr(SPR_FUNNEL_CNT, 32'hFFFFFFE0 | 32'(s));
            rd(SPR_FUNNEL_CNT, 32'(s));
            @(posedge clk);
            {extract_valid, extract_hi, extract_lo} <= {1'h1, both};
            settle();
            chk(extract_q, 32'((both << s) >> 32));
            chk(32'(extract_done_q), 32'h1);
        end
    endtask

    // Generous limit: the whole sequence needs well under a thousand cycles.
    initial begin
        #100000;
        bad_count++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'h0;
        settle();
        rd(SPR_FLOAT_ENV, 32'h0);
        t_pointers();
        t_operands();
        t_float_env();
        t_int_env();
        t_alu();
        t_lanes();
        t_funnel();
        conclude();
    end
endmodule

// [inc/sprb_alu_if.sv]
// Carrier between the bank and its ALU status register.
`timescale 1ns/1ns
interface sprb_alu_if;
    logic arith_valid;
    logic logic_valid;
    logic [31:0] result;
    logic carry_out;
    logic carry_msb;
    logic div_end;
    logic div_force_one;
    logic alu_bit32;
    logic wr_status;
    logic wr_bp;
    logic wr_fc;
    logic [31:0] wr_data;
    logic ls_set_bp;
    logic byte_order;
    logic [11:0] status;
    modport ctl (output arith_valid, logic_valid, result, carry_out, carry_msb, div_end,
        div_force_one, alu_bit32, wr_status, wr_bp, wr_fc, wr_data, ls_set_bp, byte_order,
        input status);
    modport stat (input arith_valid, logic_valid, result, carry_out, carry_msb, div_end,
        div_force_one, alu_bit32, wr_status, wr_bp, wr_fc, wr_data, ls_set_bp, byte_order,
        output status);
endinterface

// [inc/sprb_pkg.sv]
// Constants and types for the special-register operand and status bank.
// How it works
// - A zero result, source-A or source-B field takes its number from its pointer.
// - Each pointer holds eight bits at 9..2; bits 1..0 read zero.
// - A pointer number selects its register directly, with no stack-pointer add.
// - Fast-float select at one runs floating point in the relaxed fast mode.
// - Round mode field: 00 nearest, 01 minus, 10 plus, 11 toward zero.
// - Divide-by-zero mask clear traps a finite non-zero divide by zero.
// - Inexact mask clear traps a result differing from the exact value.
// - Underflow mask clear traps a result too small for its format.
// - Overflow mask clear traps a result too large for its format.
// - Reserved-operand mask clear traps reserved input or result values.
// - Invalid-operation mask clear traps operands giving an indeterminate result.
// - Division overflow mask clear traps a divide whose 32-bit result overflows.
// - A zero divisor always raises the out-of-range trap.
// - Multiply overflow mask clear traps a multiply whose 32-bit result overflows.
// - Divide flag ends divides at one or inverted bit 32; steers divide step.
// - Overflow flag is carry-out exclusive-OR carry into the top bit.
// - Negative flag takes the result's top bit, even on overflow.
// - Zero flag is set when the result is zero.
// - Carry flag captures carry-out and feeds add and subtract with carry.
// - Byte pointer picks byte and half-word lanes according to byte order.
// - Moves load the byte pointer; a set-byte-pointer load or store loads inverted order.
// - Extract takes 32 bits from a 64-bit join, shift count below the top.
// - Reserved fields read zero and writes to them do nothing.
// - A move into a pointer loads it from bits 9..2 of the source.
package sprb_pkg;
    // Special-register numbers.
    localparam logic [7:0] SPR_PTR_RESULT = 8'h80;
    localparam logic [7:0] SPR_PTR_SRC_A = 8'h81;
    localparam logic [7:0] SPR_PTR_SRC_B = 8'h82;
    localparam logic [7:0] SPR_ALU_STATUS = 8'h84;
    localparam logic [7:0] SPR_BYTE_PTR = 8'h85;
    localparam logic [7:0] SPR_FUNNEL_CNT = 8'h86;
    localparam logic [7:0] SPR_FLOAT_ENV = 8'hA0;
    localparam logic [7:0] SPR_WHOLE_ENV = 8'hA1;
    // Pointer field position.
    localparam int PTR_LSB = 2;
    localparam int PTR_MSB = 9;
    // Float environment fields.
    localparam int FE_FAST_BIT = 8;
    localparam int FE_ROUND_LSB = 6;
    localparam int FE_WIDTH = 9;
    // Whole-number environment fields.
    localparam int WE_DIV_BIT = 1;
    localparam int WE_MUL_BIT = 0;
    localparam int WE_WIDTH = 2;
    // ALU status fields.
    localparam int AS_DF_BIT = 11;
    localparam int AS_V_BIT = 10;
    localparam int AS_N_BIT = 9;
    localparam int AS_Z_BIT = 8;
    localparam int AS_C_BIT = 7;
    localparam int AS_BP_LSB = 5;
    localparam int AS_FC_LSB = 0;
    localparam int AS_WIDTH = 12;
    // Values after reset.
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [8:0] FE_RESET = 9'h000;
    localparam logic [1:0] WE_RESET = 2'h0;
    localparam logic [11:0] AS_RESET = 12'h000;
    localparam logic [6:0] SP_RESET = 7'h00;
    // Round modes.
    typedef enum logic [1:0] {
        SPRB_RND_NEAREST = 2'h0,
        SPRB_RND_MINUS = 2'h1,
        SPRB_RND_PLUS = 2'h2,
        SPRB_RND_ZERO = 2'h3
    } sprb_round_t;
endpackage

// [rtl/sprb_alu_status.sv]
// ALU status register: flags, byte pointer and funnel shift count.
`timescale 1ns/1ns
module sprb_alu_status import sprb_pkg::*; (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Event and move carrier.
    sprb_alu_if.stat bus
);
    logic [11:0] status_q;
    assign bus.status = status_q;

    // Moves load first; hardware events in the same cycle override them.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_q <= AS_RESET;
        end else begin
            if (bus.wr_status) begin
                status_q <= bus.wr_data[11:0];
            end
            if (bus.wr_bp) begin
                status_q[AS_BP_LSB +: 2] <= bus.wr_data[1:0];
            end
            if (bus.wr_fc) begin
                status_q[AS_FC_LSB +: 5] <= bus.wr_data[4:0];
            end
            if (bus.arith_valid) begin
                status_q[AS_V_BIT] <= bus.carry_out ^ bus.carry_msb;
                status_q[AS_C_BIT] <= bus.carry_out;
            end
            if (bus.arith_valid || bus.logic_valid) begin
                status_q[AS_N_BIT] <= bus.result[31];
                status_q[AS_Z_BIT] <= (bus.result == 32'h0000_0000);
            end
            if (bus.div_end) begin
                status_q[AS_DF_BIT] <= bus.div_force_one | ~bus.alu_bit32;
            end
            if (bus.ls_set_bp) begin
                status_q[AS_BP_LSB +: 2] <= {2{~bus.byte_order}};
            end
        end
    end

    sequence s_arith;
        bus.arith_valid;
    endsequence

    carry_capture_a: assert property (@(posedge clk) disable iff (sys_rst)
        s_arith |=> status_q[AS_C_BIT] == $past(bus.carry_out))
        else $error("Carry flag missed the carry-out.");
    overflow_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        s_arith |=> status_q[AS_V_BIT] == ($past(bus.carry_out) ^ $past(bus.carry_msb)))
        else $error("Overflow flag wrong.");
    zero_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        (bus.arith_valid || bus.logic_valid) && bus.result == 32'h0 |=> status_q[AS_Z_BIT])
        else $error("Zero flag not set on zero result.");
    bp_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        bus.ls_set_bp |=> status_q[AS_BP_LSB +: 2] == {2{~$past(bus.byte_order)}})
        else $error("Byte pointer not loaded from byte order.");
endmodule

// [rtl/sprb_top.sv]
// Special-register bank: indirect pointers, environments and ALU status.
`timescale 1ns/1ns
module sprb_top import sprb_pkg::*; (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Special-register move port.
    input wire logic spr_wr_en,
    input wire logic [7:0] spr_wr_num,
    input wire logic [31:0] spr_wr_data,
    input wire logic spr_rd_en,
    input wire logic [7:0] spr_rd_num,
    output logic [31:0] spr_rd_data_q,
    output logic spr_rd_valid_q,
    // Operand field resolution.
    input wire logic opnd_valid,
    input wire logic [7:0] result_reg_field,
    input wire logic [7:0] src_a_reg_field,
    input wire logic [7:0] src_b_reg_field,
    output logic [7:0] result_abs_q,
    output logic [7:0] src_a_abs_q,
    output logic [7:0] src_b_abs_q,
    output logic opnd_done_q,
    // Stack-pointer shadow and bulk pointer set.
    input wire logic sp_wr_valid,
    input wire logic [31:0] sp_wr_value,
    input wire logic ipset_valid,
    input wire logic [7:0] ipset_result,
    input wire logic [7:0] ipset_src_a,
    input wire logic [7:0] ipset_src_b,
    // ALU events.
    input wire logic alu_arith_valid,
    input wire logic alu_logic_valid,
    input wire logic [31:0] alu_result,
    input wire logic alu_carry_out,
    input wire logic alu_carry_msb,
    input wire logic div_end,
    input wire logic div_force_one,
    input wire logic alu_bit32,
    output logic alu_carry_in,
    output logic div_step_add,
    // Byte lanes and funnel shifter.
    input wire logic byte_order_bit,
    input wire logic ls_valid,
    input wire logic set_byte_ptr_flag,
    output logic [1:0] byte_lane_sel,
    output logic half_lane_sel,
    input wire logic extract_valid,
    input wire logic [31:0] extract_hi,
    input wire logic [31:0] extract_lo,
    output logic [31:0] extract_q,
    output logic extract_done_q,
    // Floating-point environment use.
    output logic fast_float_select,
    output sprb_round_t round_mode_field,
    input wire logic fp_done,
    input wire logic [5:0] fp_exc,
    output logic fp_trap_q,
    output logic [5:0] fp_trap_cause_q,
    // Integer environment use.
    input wire logic int_done,
    input wire logic int_is_div,
    input wire logic int_overflow,
    input wire logic int_div_zero,
    output logic range_trap_q
);
    logic [7:0] ptr_result_q;
    logic [7:0] ptr_src_a_q;
    logic [7:0] ptr_src_b_q;
    logic [8:0] float_env_q;
    logic [1:0] whole_env_q;
    logic [6:0] sp_base_q;
    logic [11:0] status;
    logic [63:0] funnel_cat;
    logic [5:0] fp_unmasked;
    logic int_trap;

    sprb_alu_if alu_bus ();

    // Write strobe for one special register.
    function automatic logic spr_hit(input logic en, input logic [7:0] num,
        input logic [7:0] target);
        return en && (num == target);
    endfunction

    // Absolute register number for one operand field.
    function automatic logic [7:0] resolve_field(input logic [7:0] fld,
        input logic [7:0] ptr, input logic [6:0] sp_base);
        logic [6:0] local_sum;
        local_sum = 7'(fld[6:0] + sp_base);
        if (fld == 8'h00) begin
            return ptr;
        end else if (fld[7]) begin
            return {1'b1, local_sum};
        end else begin
            return fld;
        end
    endfunction

    // Indirect pointers; a bulk set by the instruction beats a move in the same cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr_result_q <= PTR_RESET;
            ptr_src_a_q <= PTR_RESET;
            ptr_src_b_q <= PTR_RESET;
        end else if (ipset_valid) begin
            ptr_result_q <= ipset_result;
            ptr_src_a_q <= ipset_src_a;
            ptr_src_b_q <= ipset_src_b;
        end else begin
            if (spr_hit(spr_wr_en, spr_wr_num, SPR_PTR_RESULT)) begin
                ptr_result_q <= spr_wr_data[PTR_MSB:PTR_LSB];
            end
            if (spr_hit(spr_wr_en, spr_wr_num, SPR_PTR_SRC_A)) begin
                ptr_src_a_q <= spr_wr_data[PTR_MSB:PTR_LSB];
            end
            if (spr_hit(spr_wr_en, spr_wr_num, SPR_PTR_SRC_B)) begin
                ptr_src_b_q <= spr_wr_data[PTR_MSB:PTR_LSB];
            end
        end
    end

    // Stack-pointer base is registered so a change takes effect one cycle later.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sp_base_q <= SP_RESET;
        end else if (sp_wr_valid) begin
            sp_base_q <= sp_wr_value[8:2];
        end
    end

    // Operand resolution; the pointers are never rewritten here.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_abs_q <= 8'h00;
            src_a_abs_q <= 8'h00;
            src_b_abs_q <= 8'h00;
            opnd_done_q <= 1'b0;
        end else begin
            opnd_done_q <= opnd_valid;
            if (opnd_valid) begin
                result_abs_q <= resolve_field(result_reg_field, ptr_result_q, sp_base_q);
                src_a_abs_q <= resolve_field(src_a_reg_field, ptr_src_a_q, sp_base_q);
                src_b_abs_q <= resolve_field(src_b_reg_field, ptr_src_b_q, sp_base_q);
            end
        end
    end

    // Environments keep only their defined bits, so reserved writes vanish.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            float_env_q <= FE_RESET;
            whole_env_q <= WE_RESET;
        end else begin
            if (spr_hit(spr_wr_en, spr_wr_num, SPR_FLOAT_ENV)) begin
                float_env_q <= spr_wr_data[FE_WIDTH-1:0];
            end
            if (spr_hit(spr_wr_en, spr_wr_num, SPR_WHOLE_ENV)) begin
                whole_env_q <= spr_wr_data[WE_WIDTH-1:0];
            end
        end
    end

    // Mode outputs steer the arithmetic unit directly.
    assign fast_float_select = float_env_q[FE_FAST_BIT];
    assign round_mode_field = sprb_round_t'(float_env_q[FE_ROUND_LSB +: 2]);

    // Exception bits line up with mask bits 5..0, so one AND covers every cause.
    assign fp_unmasked = fp_exc & ~float_env_q[5:0];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fp_trap_q <= 1'b0;
            fp_trap_cause_q <= 6'h00;
        end else begin
            fp_trap_q <= fp_done && (fp_unmasked != 6'h00);
            if (fp_done && (fp_unmasked != 6'h00)) begin
                fp_trap_cause_q <= fp_exc;
            end
        end
    end

    // A zero divisor ignores the mask; overflow obeys it.
    assign int_trap = int_done && (int_is_div ?
        (int_div_zero || (int_overflow && !whole_env_q[WE_DIV_BIT])) :
        (int_overflow && !whole_env_q[WE_MUL_BIT]));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            range_trap_q <= 1'b0;
        end else begin
            range_trap_q <= int_trap;
        end
    end

    // ALU status register hookup.
    assign alu_bus.arith_valid = alu_arith_valid;
    assign alu_bus.logic_valid = alu_logic_valid;
    assign alu_bus.result = alu_result;
    assign alu_bus.carry_out = alu_carry_out;
    assign alu_bus.carry_msb = alu_carry_msb;
    assign alu_bus.div_end = div_end;
    assign alu_bus.div_force_one = div_force_one;
    assign alu_bus.alu_bit32 = alu_bit32;
    assign alu_bus.wr_status = spr_hit(spr_wr_en, spr_wr_num, SPR_ALU_STATUS);
    assign alu_bus.wr_bp = spr_hit(spr_wr_en, spr_wr_num, SPR_BYTE_PTR);
    assign alu_bus.wr_fc = spr_hit(spr_wr_en, spr_wr_num, SPR_FUNNEL_CNT);
    assign alu_bus.wr_data = spr_wr_data;
    assign alu_bus.ls_set_bp = ls_valid && set_byte_ptr_flag;
    assign alu_bus.byte_order = byte_order_bit;
    assign status = alu_bus.status;

    sprb_alu_status u_alu_status (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus(alu_bus)
    );

    // Flags feed back into the ALU.
    assign alu_carry_in = status[AS_C_BIT];
    assign div_step_add = ~status[AS_DF_BIT];

    // Lane mapping: with byte order set, pointer 0 names the most significant byte.
    assign byte_lane_sel = byte_order_bit ? ~status[AS_BP_LSB +: 2] :
        status[AS_BP_LSB +: 2];
    assign half_lane_sel = byte_order_bit ? ~status[AS_BP_LSB + 1] :
        status[AS_BP_LSB + 1];

    // Funnel shifter; a full 64-bit shift keeps the timing simple at some area cost.
    assign funnel_cat = {extract_hi, extract_lo} << status[AS_FC_LSB +: 5];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            extract_q <= 32'h0000_0000;
            extract_done_q <= 1'b0;
        end else begin
            extract_done_q <= extract_valid;
            if (extract_valid) begin
                extract_q <= funnel_cat[63:32];
            end
        end
    end

    // Read path; unmapped numbers return zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spr_rd_data_q <= 32'h0000_0000;
            spr_rd_valid_q <= 1'b0;
        end else begin
            spr_rd_valid_q <= spr_rd_en;
            if (spr_rd_en) begin
                unique case (spr_rd_num)
                    SPR_PTR_RESULT: spr_rd_data_q <= {22'h0, ptr_result_q, 2'h0};
                    SPR_PTR_SRC_A: spr_rd_data_q <= {22'h0, ptr_src_a_q, 2'h0};
                    SPR_PTR_SRC_B: spr_rd_data_q <= {22'h0, ptr_src_b_q, 2'h0};
                    SPR_ALU_STATUS: spr_rd_data_q <= {20'h0, status};
                    SPR_BYTE_PTR: spr_rd_data_q <= {30'h0, status[AS_BP_LSB +: 2]};
                    SPR_FUNNEL_CNT: spr_rd_data_q <= {27'h0, status[AS_FC_LSB +: 5]};
                    SPR_FLOAT_ENV: spr_rd_data_q <= {23'h0, float_env_q};
                    SPR_WHOLE_ENV: spr_rd_data_q <= {30'h0, whole_env_q};
                    default: spr_rd_data_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks on the pointer, trap and shifter paths.
    sequence s_ptr_move;
        spr_wr_en && spr_wr_num == SPR_PTR_SRC_A && !ipset_valid;
    endsequence

    sequence s_ptr_readback;
        spr_rd_en && spr_rd_num == SPR_PTR_SRC_A && !spr_wr_en && !ipset_valid;
    endsequence

    sequence s_fp_unmasked;
        fp_done && (fp_exc & ~float_env_q[5:0]) != 6'h00;
    endsequence

    ptr_move_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        s_ptr_move ##1 s_ptr_readback |=> spr_rd_data_q == {22'h0, $past(spr_wr_data[9:2], 2), 2'h0})
        else $error("Pointer move did not read back from bits 9 to 2.");
    ptr_align_a: assert property (@(posedge clk) disable iff (sys_rst)
        spr_rd_en && spr_rd_num == SPR_PTR_RESULT |=> spr_rd_data_q[1:0] == 2'h0
        && spr_rd_data_q[31:10] == 22'h0)
        else $error("Pointer read shows bits outside 9 to 2.");
    indirect_select_a: assert property (@(posedge clk) disable iff (sys_rst)
        opnd_valid && src_b_reg_field == 8'h00 |=> src_b_abs_q == $past(ptr_src_b_q))
        else $error("Zero field did not take the pointer.");
    no_sp_add_a: assert property (@(posedge clk) disable iff (sys_rst)
        opnd_valid && src_a_reg_field == 8'h00 && ptr_src_a_q[7] |=>
        src_a_abs_q == $past(ptr_src_a_q))
        else $error("Stack-pointer offset added to a pointer number.");
    sp_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
        sp_wr_valid ##1 (opnd_valid && src_a_reg_field == 8'h80 && !sp_wr_valid) |=>
        src_a_abs_q == {1'b1, $past(sp_wr_value[8:2], 2)})
        else $error("Local addressing ignored the stack-pointer change.");
    fp_trap_raise_a: assert property (@(posedge clk) disable iff (sys_rst)
        s_fp_unmasked |=> fp_trap_q && fp_trap_cause_q == $past(fp_exc))
        else $error("Unmasked float exception did not trap.");
    fp_trap_masked_a: assert property (@(posedge clk) disable iff (sys_rst)
        fp_done && (fp_exc & ~float_env_q[5:0]) == 6'h00 |=> !fp_trap_q)
        else $error("Masked float exception trapped.");
    div_zero_trap_a: assert property (@(posedge clk) disable iff (sys_rst)
        int_done && int_is_div && int_div_zero |=> range_trap_q)
        else $error("Zero divisor did not trap.");
    mul_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
        int_done && !int_is_div && int_overflow |=> range_trap_q == !$past(whole_env_q[0]))
        else $error("Multiply overflow mask not obeyed.");
    extract_shift_a: assert property (@(posedge clk) disable iff (sys_rst)
        extract_valid && status[4:0] == 5'h00 |=> extract_q == $past(extract_hi))
        else $error("Zero shift count did not return the upper word.");
endmodule
